// ===== inc/pbl_params.svh
// Constants for the bridge lock and subsystem identification block
`ifndef PBL_PARAMS_SVH
`define PBL_PARAMS_SVH
`define PBL_OFF_SUBSYS 8'h40
`define PBL_OFF_SYSCTL 8'h80
`define PBL_BIT_IDWE 5
`define PBL_RST_SUBSYS 32'h0000_0000
`define PBL_RST_SYSCTL 32'h0000_0000
`define PBL_RST_ROUTE 4'h0
`define PBL_ROUTE_LOCK 4'h5
`define PBL_LOCK_LSB 4
`define PBL_EE_ADDR 7'h50
`define PBL_EE_WORD 8'h00
`define PBL_SCL_HALF_NS 5000
`define PBL_CLK_NS 100
`define PBL_SCL_HALF_CYC ((`PBL_SCL_HALF_NS + `PBL_CLK_NS - 1) / `PBL_CLK_NS)
`endif

// ===== inc/pbl_pkg.sv
// Types for the bridge lock and subsystem identification block
package pbl_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [31:0] wdata;
        logic [3:0] func;
    } pbl_cfg_req_s;
    typedef struct packed {
        logic valid;
        logic write;
        logic locked;
        logic [31:0] addr;
    } pbl_txn_s;
    typedef enum logic [5:0] {
        EE_IDLE = 6'b00_0001,
        EE_START = 6'b00_0010,
        EE_SHIFT = 6'b00_0100,
        EE_ACK = 6'b00_1000,
        EE_READ = 6'b01_0000,
        EE_STOP = 6'b10_0000
    } pbl_ee_e;
    typedef logic [27:0] pbl_blk_t;
endpackage

// ===== logic/pbl_bridge.sv
// Lock forwarding and subsystem identification core of the card bus bridge
`timescale 1ns/1ps
`include "pbl_params.svh"
module pbl_bridge
    import pbl_pkg::*;
(
    // Clock, reset and control
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic suspend,
    input wire logic global_reset_input_n,
    // Configuration access
    input wire pbl_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // Multifunction terminal four routing and lock pin
    input wire logic [3:0] mfunc_route,
    input wire logic multipurpose_terminal_four,
    // Transactions through the bridge
    input wire pbl_txn_s down_txn,
    input wire pbl_txn_s up_txn,
    output logic down_go,
    output logic up_go,
    output logic post_enable,
    output logic lock_held,
    // Card bus lock pin
    output logic card_lock_n_o,
    output logic card_lock_oe,
    // Interrupt request and driver enable
    input wire logic irq_src,
    output logic inta_n_o,
    output logic inta_oe,
    output logic out_drv_en,
    // Serial EEPROM pins
    input wire logic ee_scl_i,
    output logic ee_scl_o,
    output logic ee_scl_oe,
    input wire logic ee_sda_i,
    output logic ee_sda_o,
    output logic ee_sda_oe,
    input wire logic ee_present
);
    function automatic logic same_blk(input logic [31:0] a, input pbl_blk_t b);
        same_blk = (a[31:`PBL_LOCK_LSB] == b);
    endfunction

    // Core reset: primary reset gated by suspend
    wire core_rst = !nrst && !suspend;
    wire adv = clk_en;

    logic [31:0] subsys;
    logic [31:0] sysctl;
    pbl_blk_t lock_blk;
    logic lock_act;
    logic lock_pend;

    // Lock pin is only meaningful when routed
    wire lock_routed = (mfunc_route == `PBL_ROUTE_LOCK);
    wire lock_in = lock_routed && !multipurpose_terminal_four;
    wire ident_write_enable = sysctl[`PBL_BIT_IDWE];
    wire fn_ok = (cfg_req.func <= 4'h1);
    wire hit_id = cfg_req.valid && fn_ok && cfg_req.offset == `PBL_OFF_SUBSYS;
    wire hit_sc = cfg_req.valid && fn_ok && cfg_req.offset == `PBL_OFF_SYSCTL;
    wire id_wr = hit_id && cfg_req.write && ident_write_enable;
    wire conflict = lock_act && same_blk(down_txn.addr, lock_blk);
    // Downstream: locked owner or non-conflicting access proceeds
    wire down_ok = down_txn.valid && (down_txn.locked || !conflict);
    // Upstream ignores lock entirely
    wire up_ok = up_txn.valid;
    wire start_lock = down_txn.valid && down_txn.locked && lock_in && !lock_act;
    wire [31:0] ee_word;
    wire ee_done;

    // Lock tracking, independent of grant
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            lock_act <= 1'b0;
            lock_blk <= '0;
        end else if (adv) begin
            if (start_lock) begin
                lock_act <= 1'b1;
                lock_blk <= down_txn.addr[31:`PBL_LOCK_LSB];
            end else if (lock_act && !lock_in) begin
                lock_act <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            sysctl <= `PBL_RST_SYSCTL;
            subsys <= `PBL_RST_SUBSYS;
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else if (adv) begin
            cfg_ack <= cfg_req.valid;
            if (hit_sc && cfg_req.write)
                sysctl <= cfg_req.wdata;
            if (id_wr)
                subsys <= cfg_req.wdata;
            else if (ee_done)
                subsys <= ee_word;
            cfg_rdata <= hit_id ? subsys : (hit_sc ? sysctl : 32'h0000_0000);
        end
    end

    // Transaction pass and posting control
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            down_go <= 1'b0;
            up_go <= 1'b0;
            post_enable <= 1'b1;
            lock_held <= 1'b0;
            card_lock_n_o <= 1'b1;
            lock_pend <= 1'b0;
        end else if (adv) begin
            down_go <= down_ok;
            up_go <= up_ok;
            post_enable <= !(lock_act || start_lock);
            lock_held <= lock_act || start_lock;
            lock_pend <= lock_act || start_lock;
            card_lock_n_o <= !(lock_act || start_lock);
        end
    end

    // Pin drivers released under global reset
    always_ff @(posedge clk_sys) begin
        if (!global_reset_input_n) begin
            out_drv_en <= 1'b0;
            card_lock_oe <= 1'b0;
            inta_oe <= 1'b0;
            inta_n_o <= 1'b1;
        end else if (adv) begin
            out_drv_en <= 1'b1;
            card_lock_oe <= lock_pend;
            inta_n_o <= !irq_src;
            inta_oe <= irq_src;
        end
    end

    // Serial EEPROM reader
    pbl_ee_e st;
    logic [7:0] div;
    logic phase;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh;
    logic [31:0] acc;
    logic done_r;
    logic sda_low;
    logic sda_dly;
    // A slave holding the clock low stretches the current half bit
    wire stall = ee_scl_o && !ee_scl_i;
    wire tick = !stall && (div == 8'(`PBL_SCL_HALF_CYC - 1));
    // Address byte: write direction first, read direction after the restart
    wire [7:0] tx_byte = {`PBL_EE_ADDR, byten[1]};
    // Master acknowledges the first three data bytes and refuses the last
    wire rd_ack = (bitn == 4'h8) && (byten != 2'd3);
    assign ee_word = acc;
    assign ee_done = done_r;

    // Serial bus engine held in reset with the core
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            st <= EE_START;
            div <= 8'h00;
            phase <= 1'b0;
            bitn <= 4'h0;
            byten <= 2'd0;
            sh <= 8'h00;
            acc <= 32'h0000_0000;
            done_r <= 1'b0;
            sda_low <= 1'b0;
            ee_scl_o <= 1'b1;
        end else if (adv) begin
            done_r <= 1'b0;
            div <= tick ? 8'h00 : (stall ? div : div + 8'h01);
            if (tick) begin
                phase <= !phase;
                unique case (st)
                    EE_IDLE: begin
                        ee_scl_o <= 1'b1;
                        sda_low <= 1'b0;
                    end
                    // Low clock with data released, high clock, then data falls
                    EE_START: begin
                        if (!ee_present) begin
                            st <= EE_IDLE;
                        end else if (!bitn[0]) begin
                            ee_scl_o <= phase;
                            sda_low <= 1'b0;
                            bitn <= {3'b000, phase};
                        end else if (!phase) begin
                            sda_low <= 1'b1;
                        end else begin
                            sh <= tx_byte;
                            bitn <= 4'h0;
                            st <= EE_SHIFT;
                        end
                    end
                    EE_SHIFT: begin
                        ee_scl_o <= phase;
                        if (!phase) begin
                            sda_low <= !sh[7];
                        end else begin
                            sh <= {sh[6:0], 1'b0};
                            bitn <= bitn + 4'h1;
                            if (bitn == 4'h7)
                                st <= EE_ACK;
                        end
                    end
                    EE_ACK: begin
                        ee_scl_o <= phase;
                        sda_low <= 1'b0;
                        if (phase) begin
                            bitn <= 4'h0;
                            if (ee_sda_i) begin
                                st <= EE_STOP;
                            end else if (byten == 2'd0) begin
                                byten <= 2'd1;
                                sh <= `PBL_EE_WORD;
                                st <= EE_SHIFT;
                            end else if (byten == 2'd1) begin
                                byten <= 2'd2;
                                st <= EE_START;
                            end else begin
                                byten <= 2'd0; // Now counts received bytes
                                st <= EE_READ;
                            end
                        end
                    end
                    // Eight data bits MSB first, then the master's answer bit
                    EE_READ: begin
                        ee_scl_o <= phase;
                        if (!phase) begin
                            sda_low <= rd_ack;
                        end else if (bitn != 4'h8) begin
                            sh <= {sh[6:0], ee_sda_i};
                            bitn <= bitn + 4'h1;
                        end else begin
                            acc <= {sh, acc[31:8]}; // Low byte arrives first
                            bitn <= 4'h0;
                            byten <= byten + 2'd1;
                            if (byten == 2'd3) begin
                                done_r <= 1'b1;
                                st <= EE_STOP;
                            end
                        end
                    end
                    // Low clock with data low, high clock, then data rises
                    EE_STOP: begin
                        if (!bitn[0]) begin
                            ee_scl_o <= phase;
                            sda_low <= 1'b1;
                            bitn <= {3'b000, phase};
                        end else if (!phase) begin
                            sda_low <= 1'b0;
                        end else begin
                            st <= EE_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain serial pins; data moves a cycle after the clock falls
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            ee_sda_o <= 1'b0;
            ee_sda_oe <= 1'b0;
            ee_scl_oe <= 1'b0;
            sda_dly <= 1'b0;
        end else if (adv) begin
            ee_sda_o <= 1'b0;
            sda_dly <= sda_low;
            ee_sda_oe <= sda_dly;
            ee_scl_oe <= !ee_scl_o;
        end
    end

    // Checks
    sequence s_lock_start;
        adv && start_lock;
    endsequence
    a_post_off_lock: assert property (@(posedge clk_sys) disable iff (core_rst)
        s_lock_start |=> !post_enable) else $error("posting during lock");
    a_card_lock_follow: assert property (@(posedge clk_sys) disable iff (core_rst)
        s_lock_start |=> !card_lock_n_o) else $error("card lock not held");
    a_route_gate: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && !lock_routed && !lock_act) |=> !lock_act) else $error("unrouted lock");
    a_up_ignores_lock: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && up_txn.valid) |=> up_go) else $error("upstream blocked");
    a_outside_proceed: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && down_txn.valid && !conflict) |=> down_go) else $error("outside blocked");
    a_block_conflict: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && down_txn.valid && !down_txn.locked && conflict) |=> !down_go)
        else $error("conflict passed");
    a_id_protect: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && hit_id && cfg_req.write && !ident_write_enable && !ee_done)
        |=> $stable(subsys)) else $error("id written while protected");
    a_id_write: assert property (@(posedge clk_sys) disable iff (core_rst)
        (adv && id_wr) |=> subsys == $past(cfg_req.wdata)) else $error("id write lost");
    a_drv_off_global_reset_input: assert property (@(posedge clk_sys)
        !global_reset_input_n |=> !out_drv_en && !card_lock_oe) else $error("drivers on");
endmodule

// ===== sim/pbl_ee_model.sv
// Behavioural two-wire EEPROM holding the identification bytes
`timescale 1ns/1ps
module pbl_ee_model #(
    parameter logic [6:0] DEV = 7'h50,
    parameter logic [31:0] IDENT = 32'h5A3C_96E1 // Arbitrary content
) (
    // Bus levels and data pull-down
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic act = 1'b0;
    logic first = 1'b0;
    logic rdg = 1'b0;
    int cnt = 0;
    initial sda_pull = 1'b0;
    // Start opens a frame
    always @(negedge sda) begin
        if (scl) begin
            act = 1'b1;
            first = 1'b1;
            rdg = 1'b0;
            cnt = -1;
        end
    end
    // Stop closes it
    always @(posedge sda) begin
        if (scl) begin
            act = 1'b0;
        end
    end
    // Sample bits; a master nack ends the read
    always @(posedge scl) begin
        if (act && cnt < 8) begin
            sh = {sh[6:0], sda};
        end else if (act && rdg && sda) begin
            act = 1'b0;
        end
    end
    // Acknowledge and read data change after the falling clock
    always @(negedge scl) begin
        if (act) begin
            cnt = (cnt + 1) % 9;
            sda_pull = 1'b0;
            if (cnt < 8 && rdg) begin
                sda_pull = !IDENT[8 * ptr[1:0] + 7 - cnt]; // Low byte first
            end else if (cnt == 8 && rdg) begin
                ptr = ptr + 8'h01;
            end else if (cnt == 8 && first) begin
                first = 1'b0;
                rdg = sh[0];
                act = (sh[7:1] == DEV);
                sda_pull = act;
            end else if (cnt == 8) begin
                ptr = sh;
                sda_pull = 1'b1;
            end
        end
    end
endmodule

// ===== sim/tb_pbl_bridge.sv
// Self-checking bench for the lock and identification block
`timescale 1ns/1ps
`include "pbl_params.svh"
module tb_pbl_bridge
    import pbl_pkg::*;
;
    localparam logic [31:0] IDENT = 32'h5A3C_96E1; // Arbitrary content
    localparam logic [7:0] SID = `PBL_OFF_SUBSYS;
    localparam logic [7:0] SCT = `PBL_OFF_SYSCTL;
    localparam logic [31:0] WE = 32'h0000_0001 << `PBL_BIT_IDWE;
    logic clk_sys, nrst, clk_en, suspend, global_reset_input_n;
    pbl_cfg_req_s cfg_req;
    pbl_txn_s down_txn, up_txn;
    logic [31:0] cfg_rdata, rd;
    logic cfg_ack, down_go, up_go, post_enable, lock_held, card_lock_n_o, card_lock_oe, go;
    logic [3:0] mfunc_route;
    logic lock_pin, irq_src, inta_n_o, inta_oe, out_drv_en;
    logic ee_scl_o, ee_scl_oe, ee_sda_o, ee_sda_oe, ee_present, sda_pull;
    wire logic scl_line = !(ee_scl_oe && !ee_scl_o);
    wire logic sda_line = !((ee_sda_oe && !ee_sda_o) || sda_pull);
    int err_total = 0;
    int tests_run = 0;
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    pbl_bridge u_pbl_bridge (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .suspend(suspend), .global_reset_input_n(global_reset_input_n),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .mfunc_route(mfunc_route), .multipurpose_terminal_four(lock_pin),
        .down_txn(down_txn), .up_txn(up_txn), .down_go(down_go), .up_go(up_go),
        .post_enable(post_enable), .lock_held(lock_held), .card_lock_n_o(card_lock_n_o),
        .card_lock_oe(card_lock_oe), .irq_src(irq_src), .inta_n_o(inta_n_o),
        .inta_oe(inta_oe), .out_drv_en(out_drv_en), .ee_scl_i(scl_line),
        .ee_scl_o(ee_scl_o), .ee_scl_oe(ee_scl_oe), .ee_sda_i(sda_line),
        .ee_sda_o(ee_sda_o), .ee_sda_oe(ee_sda_oe), .ee_present(ee_present));
    pbl_ee_model #(.DEV(`PBL_EE_ADDR), .IDENT(IDENT)) u_pbl_ee_model (.scl(scl_line),
        .sda(sda_line), .sda_pull(sda_pull));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One configuration access, answer one cycle later
    task automatic cfg(input logic wr, input logic [7:0] off, input logic [31:0] d,
        input logic [3:0] fn);
        @(posedge clk_sys);
        cfg_req <= '{valid: 1'b1, write: wr, offset: off, wdata: d, func: fn};
        @(posedge clk_sys);
        cfg_req.valid <= 1'b0;
        #1;
        rd = cfg_rdata;
        check(32'(cfg_ack), 32'h1, "config ack");
    endtask
    // One transaction in either direction
    task automatic txn(input logic dn, input logic lk, input logic [31:0] a);
        @(posedge clk_sys);
        if (dn) down_txn <= '{valid: 1'b1, write: !lk, locked: lk, addr: a};
        else up_txn <= '{valid: 1'b1, write: !lk, locked: lk, addr: a};
        @(posedge clk_sys);
        down_txn.valid <= 1'b0;
        up_txn.valid <= 1'b0;
        #1;
        go = dn ? down_go : up_go;
    endtask
    // Poll the identification until the serial load lands
    task automatic wait_ident();
        rd = '0;
        for (int i = 0; i < 500 && rd !== IDENT; i++) begin
            tick(20);
            cfg(1'b0, SID, '0, 4'h0);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
    // Main sequence
    initial begin
        cfg_req = '0;
        down_txn = '0;
        up_txn = '0;
        {nrst, suspend, irq_src, mfunc_route} = '0;
        {clk_en, global_reset_input_n, lock_pin, ee_present} = 4'hf;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        tick(1);
        check(32'(post_enable), 32'h1, "posting after reset");
        check(32'(card_lock_n_o), 32'h1, "card lock idle");
        cfg(1'b0, SCT, '0, 4'h0);
        check(rd, `PBL_RST_SYSCTL, "control reset value");
        wait_ident();
        check(rd, IDENT, "id from eeprom");
        cfg(1'b0, SID, '0, 4'h1);
        check(rd, IDENT, "id in function 1");
        $display("test load done");
        cfg(1'b1, SID, 32'h1234_5678, 4'h0);
        cfg(1'b0, SID, '0, 4'h0);
        check(rd, IDENT, "protected id write");
        cfg(1'b1, SCT, WE, 4'h0);
        cfg(1'b1, SID, 32'h1234_5678, 4'h0);
        cfg(1'b0, SID, '0, 4'h0);
        check(rd, 32'h1234_5678, "enabled id write");
        cfg(1'b1, SCT, '0, 4'h0);
        cfg(1'b1, SID, 32'hffff_0000, 4'h0);
        cfg(1'b0, SID, '0, 4'h0);
        check(rd, 32'h1234_5678, "id locked again");
        cfg(1'b0, 8'h44, '0, 4'h0);
        check(rd, 32'h0, "unmapped read");
        $display("test id write done");
        @(posedge clk_sys);
        lock_pin <= 1'b0;
        txn(1'b1, 1'b1, 32'h1000_0004);
        tick(1);
        check(32'(lock_held), 32'h0, "lock not routed");
        @(posedge clk_sys);
        mfunc_route <= `PBL_ROUTE_LOCK;
        txn(1'b0, 1'b1, 32'h1000_0004);
        tick(1);
        check(32'(lock_held), 32'h0, "upstream lock ignored");
        txn(1'b1, 1'b1, 32'h1000_0004);
        tick(1);
        check(32'(lock_held), 32'h1, "lock taken");
        check(32'(post_enable), 32'h0, "posting off");
        check(32'({card_lock_n_o, card_lock_oe}), 32'h1, "card lock driven");
        txn(1'b1, 1'b0, 32'h1000_000c);
        check(32'(go), 32'h0, "same block refused");
        txn(1'b1, 1'b0, 32'h1000_0000);
        check(32'(go), 32'h0, "block base refused");
        txn(1'b1, 1'b0, 32'h1000_0010);
        check(32'(go), 32'h1, "next block passes");
        txn(1'b1, 1'b0, 32'h0fff_fffc);
        check(32'(go), 32'h1, "prior block passes");
        txn(1'b0, 1'b0, 32'h1000_0008);
        check(32'(go), 32'h1, "other initiator");
        txn(1'b1, 1'b1, 32'h1000_0008);
        check(32'(go), 32'h1, "owner keeps access");
        txn(1'b1, 1'b0, 32'h2000_0040);
        check(32'(go), 32'h1, "cache writeback passes");
        @(posedge clk_sys);
        lock_pin <= 1'b1;
        tick(2);
        check(32'({lock_held, post_enable}), 32'h1, "lock released");
        $display("test lock done");
        cfg(1'b1, SCT, WE, 4'h0);
        @(posedge clk_sys);
        suspend <= 1'b1;
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        suspend <= 1'b0;
        cfg(1'b0, SCT, '0, 4'h0);
        check(rd, WE, "reset gated by suspend");
        $display("test suspend done");
        @(posedge clk_sys);
        {nrst, ee_present} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        tick(1);
        check(32'(post_enable), 32'h1, "posting after second reset");
        tick(200);
        cfg(1'b0, SID, '0, 4'h0);
        check(rd, `PBL_RST_SUBSYS, "no eeprom fitted");
        cfg(1'b0, SCT, '0, 4'h0);
        check(rd, `PBL_RST_SYSCTL, "reset reaches core");
        @(posedge clk_sys);
        {nrst, ee_present} <= 2'b01;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        wait_ident();
        check(rd, IDENT, "id reloaded after reset");
        $display("test reload done");
        @(posedge clk_sys);
        {clk_en, irq_src} <= 2'b01;
        tick(3);
        check(32'({inta_n_o, inta_oe}), 32'h2, "frozen without enable");
        @(posedge clk_sys);
        clk_en <= 1'b1;
        tick(3);
        check(32'({inta_n_o, inta_oe}), 32'h1, "interrupt a driven");
        @(posedge clk_sys);
        global_reset_input_n <= 1'b0;
        tick(2);
        check(32'({out_drv_en, inta_oe, card_lock_oe}), 32'h0, "drivers off");
        $display("test drivers done");
        test_done();
    end
endmodule
